// File: rtl/gis_top.sv
// Second interrupt status and mask register with remote/local tracking
//
// Behaviour
// - Set service request flag on controller-side request
// - Service request flag only while controller in charge
// - Reading the register clears returned event flags
// - Reset clears request, lockout, remote, address flags
// - Bit 5 shows lockout in either lockout state
// - Lockout indication never raises an interrupt
// - Bit 4 shows remote in remote states
// - Remote entered only with enable and listener addressing
// - Command-out set when active and generate coincide
// - Command-out cleared by read or leaving states
// - Command-out set means command register is empty
// - Lockout-change set on any lockout transition
// - Remote-change set on any remote transition
// - Address-change set on any address status change
// - Address-change suppressed in listen-only or talk-only
// - Write bits 6 and 3..0 enable matching event interrupts
//
// Decided for this implementation: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module gis_top
   import gis_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        reset,
   input  wire logic        ce,
   // Avalon-MM slave
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output var  logic [31:0] avs_readdata,
   output var  logic        avs_waitrequest,
   output var  logic        irq,
   // Bus pins, active low
   input  wire logic        bus_srq_n,
   input  wire logic        bus_ren_n,
   // Interface function states on this clock
   input  wire logic        controller_in_charge_bit,
   input  wire logic        request_service,
   input  wire logic        data_valid,
   input  wire logic        controller_active_state,
   input  wire logic        source_generate_state,
   input  wire logic        listener_addressed,
   input  wire logic        lockout_cmd,
   input  wire logic        go_to_local_cmd,
   input  wire logic        return_to_local,
   input  wire logic        talker_active_bit,
   input  wire logic        listener_active_bit,
   input  wire logic        major_minor_address_bit,
   // Status toward the rest of the chip
   output var  logic        lockout_indication,
   output var  logic        remote_indication,
   output var  logic        command_output_register_empty
);

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   logic srq_n_lvl;
   logic ren_n_lvl;
   logic bus_srq;
   logic bus_ren;

   gis_sync #(.RST_LVL(1'b1)) u_sync_srq (
      .mclk  (mclk),
      .reset (reset),
      .ce    (ce),
      .pin   (bus_srq_n),
      .level (srq_n_lvl)
   );

   gis_sync #(.RST_LVL(1'b1)) u_sync_ren (
      .mclk  (mclk),
      .reset (reset),
      .ce    (ce),
      .pin   (bus_ren_n),
      .level (ren_n_lvl)
   );

   assign bus_srq = ~srq_n_lvl;
   assign bus_ren = ~ren_n_lvl;

   ////////////////////////////////////////////////////////////////////////
   // Avalon-MM slave: one wait cycle per access

   logic        wait_q;
   logic        wait_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic        req;
   logic        take;
   logic        wr_take;
   logic        rd_take;
   logic        lane0;
   logic [7:0]  wbyte;
   logic        sel_status;
   logic        sel_clear;
   logic        sel_enable;
   logic        sel_mode;

   assign req        = avs_read | avs_write;
   assign take       = req & ~wait_q;
   assign wr_take    = take & avs_write;
   assign rd_take    = take & avs_read;
   assign lane0      = avs_byteenable[0];
   assign wbyte      = avs_writedata[7:0];
   assign sel_status = (avs_address == GIS_OFF_STATUS);
   assign sel_clear  = (avs_address == GIS_OFF_CLEAR);
   assign sel_enable = (avs_address == GIS_OFF_ENABLE);
   assign sel_mode   = (avs_address == GIS_OFF_MODE);

   // Low for exactly one cycle, after one cycle of wait
   assign wait_d = ~(req & wait_q);

   ////////////////////////////////////////////////////////////////////////
   // Software registers

   logic [7:0] en_q;
   logic [7:0] en_d;
   logic [7:0] mode_q;
   logic [7:0] mode_d;
   logic       wr_status;
   logic       wr_clear;
   logic       wr_mode;

   assign wr_status = wr_take & lane0 & sel_status;
   assign wr_clear  = wr_take & lane0 & sel_clear;
   assign wr_mode   = wr_take & lane0 & sel_mode;
   // Transfer enables are stored but drive nothing
   assign en_d   = wr_status ? (wbyte & GIS_EN_MASK) : en_q;
   assign mode_d = wr_mode ? (wbyte & GIS_MODE_MASK) : mode_q;

   always_ff @(posedge mclk) begin
      if (reset) begin
         wait_q  <= 1'b1;
         rdata_q <= GIS_RD_ZERO;
         en_q    <= GIS_RST_BYTE;
         mode_q  <= GIS_RST_BYTE;
      end else if (ce) begin
         wait_q  <= wait_d;
         rdata_q <= rdata_d;
         en_q    <= en_d;
         mode_q  <= mode_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Remote/local function

   gis_rl_t rl_q;
   gis_rl_t rl_d;
   logic    enter_rmt;
   logic    gtl_addressed;
   logic    to_local;

   // Local button yields only while no lockout is in force
   assign enter_rmt     = listener_addressed & ~return_to_local;
   assign gtl_addressed = go_to_local_cmd & listener_addressed;
   assign to_local      = return_to_local | gtl_addressed;

   always_comb begin
      rl_d = rl_q;
      if (!bus_ren) begin
         rl_d = GIS_LOC;
      end else begin
         case (rl_q)
            GIS_LOC: begin
               if (enter_rmt) begin
                  rl_d = lockout_cmd ? GIS_RMT_LOCK : GIS_RMT;
               end else if (lockout_cmd) begin
                  rl_d = GIS_LOC_LOCK;
               end
            end
            GIS_RMT: begin
               if (lockout_cmd) begin
                  rl_d = GIS_RMT_LOCK;
               end else if (to_local) begin
                  rl_d = GIS_LOC;
               end
            end
            GIS_RMT_LOCK: begin
               if (gtl_addressed) begin
                  rl_d = GIS_LOC_LOCK;
               end
            end
            GIS_LOC_LOCK: begin
               // Lockout keeps the local button from releasing control
               if (listener_addressed) begin
                  rl_d = GIS_RMT_LOCK;
               end
            end
            default: begin
               rl_d = GIS_LOC;
            end
         endcase
      end
   end

   logic lock_now;
   logic rmt_now;

   assign lock_now = (rl_q == GIS_LOC_LOCK) |
                     (rl_q == GIS_RMT_LOCK);
   assign rmt_now  = (rl_q == GIS_RMT) |
                     (rl_q == GIS_RMT_LOCK);

   ////////////////////////////////////////////////////////////////////////
   // Event detection

   logic       lock_q;
   logic       rmt_q;
   logic       srq_cond_q;
   logic       co_cond_q;
   logic [3:0] addr_stat_q;
   logic [3:0] addr_stat_now;
   logic       srq_cond;
   logic       co_cond;
   logic       only_mode;
   logic       set_srq_in;
   logic       set_cmd_out;
   logic       set_lock_chg;
   logic       set_rmt_chg;
   logic       set_addr_chg;
   logic       rd_status;
   logic [6:0] set_vec;
   logic [6:0] clr_vec;
   logic [6:0] flags;

   assign srq_cond = controller_in_charge_bit & bus_srq &
                     ~(request_service & data_valid);
   assign co_cond  = controller_active_state & source_generate_state;
   assign addr_stat_now = {controller_in_charge_bit, listener_active_bit,
                           talker_active_bit, major_minor_address_bit};
   assign only_mode = mode_q[GIS_B_LON] | mode_q[GIS_B_TON];

   // Request and command-out fire on the rising edge of their condition
   assign set_srq_in   = srq_cond & ~srq_cond_q;
   assign set_cmd_out  = co_cond & ~co_cond_q;
   assign set_lock_chg = lock_now ^ lock_q;
   assign set_rmt_chg  = rmt_now ^ rmt_q;
   // Address bits are tracked while suppressed, so no stale event later
   assign set_addr_chg = (addr_stat_now != addr_stat_q) &
                         ~only_mode;
   assign rd_status    = rd_take & sel_status;

   always_comb begin
      set_vec = '0;
      set_vec[GIS_B_SRQ_IN]   = set_srq_in;
      set_vec[GIS_B_CMD_OUT]  = set_cmd_out;
      set_vec[GIS_B_LOCK_CHG] = set_lock_chg;
      set_vec[GIS_B_RMT_CHG]  = set_rmt_chg;
      set_vec[GIS_B_ADDR_CHG] = set_addr_chg;
   end

   // Only bits the read returned are cleared, so a late event survives
   always_comb begin
      clr_vec = '0;
      if (rd_status) begin
         clr_vec = rdata_q[6:0] & GIS_EVT_MASK[6:0];
      end
      if (wr_clear) begin
         clr_vec = clr_vec | (wbyte[6:0] & GIS_EVT_MASK[6:0]);
      end
      clr_vec[GIS_B_CMD_OUT] = clr_vec[GIS_B_CMD_OUT] | ~co_cond;
   end

   genvar gi;
   generate
      for (gi = 0; gi < 7; gi++) begin : g_flag
         if (GIS_EVT_MASK[gi]) begin : g_evt
            gis_flag u_flag (
               .mclk  (mclk),
               .reset (reset),
               .ce    (ce),
               .set   (set_vec[gi]),
               .clr   (clr_vec[gi]),
               .flag  (flags[gi])
            );
         end else begin : g_none
            assign flags[gi] = 1'b0;
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Read data and interrupt

   logic [7:0] status_rd;
   logic       rd_early;
   logic       irq_d;

   always_comb begin
      status_rd = {1'b0, flags};
      status_rd[GIS_B_LOCKOUT] = lock_q;
      status_rd[GIS_B_REMOTE]  = rmt_q;
   end

   // Data is latched in the wait cycle and stands in the answer cycle
   assign rd_early = req & wait_q & avs_read;

   always_comb begin
      rdata_d = GIS_RD_ZERO;
      if (rd_early) begin
         if (sel_status) begin
            rdata_d[7:0] = status_rd;
         end else if (sel_enable) begin
            rdata_d[7:0] = en_q;
         end else if (sel_mode) begin
            rdata_d[7:0] = mode_q;
         end
      end
   end

   // Status bits 5 and 4 are excluded from the gate
   assign irq_d = |(flags & en_q[6:0] & GIS_EVT_MASK[6:0]);

   always_ff @(posedge mclk) begin
      if (reset) begin
         rl_q        <= GIS_LOC;
         lock_q      <= 1'b0;
         rmt_q       <= 1'b0;
         srq_cond_q  <= 1'b0;
         co_cond_q   <= 1'b0;
         addr_stat_q <= '0;
         irq        <= 1'b0;
         command_output_register_empty <= 1'b0;
      end else if (ce) begin
         rl_q        <= rl_d;
         lock_q      <= lock_now;
         rmt_q       <= rmt_now;
         srq_cond_q  <= srq_cond;
         co_cond_q   <= co_cond;
         addr_stat_q <= addr_stat_now;
         irq         <= irq_d;
         command_output_register_empty <= flags[GIS_B_CMD_OUT];
      end
   end

   assign avs_readdata       = rdata_q;
   assign avs_waitrequest    = wait_q;
   assign lockout_indication = lock_q;
   assign remote_indication  = rmt_q;
endmodule // gis_top
`default_nettype wire

// File: rtl/gis_pkg.sv
// Constants for the second interrupt status and mask register block
package gis_pkg;
   // Register byte offsets on the Avalon-MM slave
   localparam logic [3:0] GIS_OFF_STATUS = 4'h0;
   localparam logic [3:0] GIS_OFF_CLEAR  = 4'h4;
   localparam logic [3:0] GIS_OFF_ENABLE = 4'h8;
   localparam logic [3:0] GIS_OFF_MODE   = 4'hc;
   // Read-side bit positions
   localparam int GIS_B_SRQ_IN   = 6;
   localparam int GIS_B_LOCKOUT  = 5;
   localparam int GIS_B_REMOTE   = 4;
   localparam int GIS_B_CMD_OUT  = 3;
   localparam int GIS_B_LOCK_CHG = 2;
   localparam int GIS_B_RMT_CHG  = 1;
   localparam int GIS_B_ADDR_CHG = 0;
   // Write-side positions of the unused transfer enables
   localparam int GIS_B_DMA_OUT  = 5;
   localparam int GIS_B_DMA_IN   = 4;
   // Mode register positions
   localparam int GIS_B_LON  = 6;
   localparam int GIS_B_TON  = 7;
   // Field masks and reset values
   localparam logic [7:0] GIS_EVT_MASK  = 8'h4f;
   localparam logic [7:0] GIS_EN_MASK   = 8'h7f;
   localparam logic [7:0] GIS_MODE_MASK = 8'hc0;
   localparam logic [7:0] GIS_RST_BYTE  = 8'h00;
   localparam logic [31:0] GIS_RD_ZERO  = 32'h0000_0000;
   // Remote/local function states
   typedef enum logic [1:0] {
      GIS_LOC      = 2'b00,
      GIS_RMT      = 2'b01,
      GIS_RMT_LOCK = 2'b10,
      GIS_LOC_LOCK = 2'b11
   } gis_rl_t;
endpackage

// File: rtl/gis_sync.sv
// Three-stage pin synchroniser that accepts a level once the second and third stages agree
`timescale 1ns/1ps
`default_nettype none
module gis_sync
   import gis_pkg::*;
#(
   parameter logic RST_LVL = 1'b1
) (
   input  wire logic mclk,
   input  wire logic reset,
   input  wire logic ce,
   input  wire logic pin,
   output var  logic level
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic lvl_q;

   // First stage feeds only the second
   always_ff @(posedge mclk) begin
      if (reset) begin
         s1_q  <= RST_LVL;
         s2_q  <= RST_LVL;
         s3_q  <= RST_LVL;
         lvl_q <= RST_LVL;
      end else if (ce) begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            lvl_q <= s3_q;
         end
      end
   end

   assign level = lvl_q;
endmodule // gis_sync
`default_nettype wire

// File: rtl/gis_flag.sv
// One sticky event flag: set wins over clear
`timescale 1ns/1ps
`default_nettype none
module gis_flag
   import gis_pkg::*;
(
   input  wire logic mclk,
   input  wire logic reset,
   input  wire logic ce,
   input  wire logic set,
   input  wire logic clr,
   output var  logic flag
);
   logic flag_q;
   logic flag_d;

   assign flag_d = set | (flag_q & ~clr);

   always_ff @(posedge mclk) begin
      if (reset) begin
         flag_q <= 1'b0;
      end else if (ce) begin
         flag_q <= flag_d;
      end
   end

   assign flag = flag_q;
endmodule // gis_flag
`default_nettype wire

// File: sim/gis_top_properties.sv
// Handshake and status checks on the register block ports
`timescale 1ns/1ps
`default_nettype none
module gis_top_properties (
   input wire logic        mclk,
   input wire logic        reset,
   input wire logic        ce,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        bus_ren_n,
   input wire logic        controller_active_state,
   input wire logic        source_generate_state,
   input wire logic        remote_indication,
   input wire logic        lockout_indication,
   input wire logic        command_output_register_empty
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset || !ce);
   sequence s_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_go;
      !(controller_active_state && source_generate_state)
      ##1 (controller_active_state && source_generate_state);
   endsequence
   one_wait_a: assert property (s_req |=> !avs_waitrequest)
      else $error("request not answered after one wait");
   ans_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("answer longer than one cycle");
   idle_zero_a: assert property (avs_waitrequest |-> avs_readdata == 32'h0)
      else $error("read data not zero outside answer");
   high_zero_a: assert property (avs_readdata[31:8] == 24'h0)
      else $error("upper read data not zero");
   cmd_set_a: assert property (
      s_go |-> ##[1:4] command_output_register_empty)
      else $error("command-out not set");
   cmd_drop_a: assert property (
      $fell(controller_active_state) || $fell(source_generate_state)
      |-> ##[1:4] !command_output_register_empty)
      else $error("command-out not cleared");
   remote_entry_a: assert property (
      $rose(remote_indication) |-> !bus_ren_n)
      else $error("remote entered without enable");
   local_return_a: assert property (
      $rose(bus_ren_n) |-> ##[2:8] !remote_indication && !lockout_indication)
      else $error("enable release did not return to local");
endmodule // gis_top_properties
bind gis_top gis_top_properties u_props (.mclk, .reset, .ce, .avs_read,
   .avs_write, .avs_readdata, .avs_waitrequest, .bus_ren_n,
   .controller_active_state, .source_generate_state, .remote_indication,
   .lockout_indication, .command_output_register_empty);
`default_nettype wire

// File: sim/gis_bus_model.sv
// Far-side bus model: open-drain request and enable lines
`timescale 1ns/1ps
`default_nettype none
module gis_bus_model (
   input  wire logic srq_on,
   input  wire logic ren_on,
   output var  logic bus_srq_n,
   output var  logic bus_ren_n
);
   // Released lines rest at the pull-up level
   always_comb bus_srq_n = !srq_on;
   always_comb bus_ren_n = !ren_on;
endmodule // gis_bus_model
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench for the second interrupt status register
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        mclk = 1'b0;
   logic        reset = 1'b1;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        irq;
   logic        bus_srq_n;
   logic        bus_ren_n;
   logic        srq_on = 1'b0;
   logic        ren_on = 1'b0;
   logic        request_service = 1'b0;
   logic        data_valid = 1'b0;
   logic        controller_active_state = 1'b0;
   logic        source_generate_state = 1'b0;
   logic        listener_addressed = 1'b0;
   logic        lockout_cmd = 1'b0;
   logic [3:0]  adr = 4'h0;
   logic        lockout_indication;
   logic        remote_indication;
   logic        command_output_register_empty;
   int          mismatches = 0;
   int          checks_done = 0;
   initial begin
      forever #12.5 mclk = ~mclk;
   end
   gis_top u_gis_top (.mclk, .reset, .ce(1'b1), .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_byteenable(4'h1), .avs_readdata,
      .avs_waitrequest, .irq, .bus_srq_n, .bus_ren_n,
      .controller_in_charge_bit(adr[2]), .request_service, .data_valid,
      .controller_active_state, .source_generate_state,
      .listener_addressed, .lockout_cmd, .go_to_local_cmd(1'b0),
      .return_to_local(1'b0), .talker_active_bit(adr[0]),
      .listener_active_bit(adr[1]), .major_minor_address_bit(adr[3]),
      .lockout_indication, .remote_indication,
      .command_output_register_empty);
   gis_bus_model u_gis_bus_model (.srq_on, .ren_on, .bus_srq_n, .bus_ren_n);
   task results();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // Request held until waitrequest is sampled low
   task bus(input logic w, input logic [3:0] a, input logic [7:0] d,
            output logic [31:0] q);
      int i;
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_read <= !w;
      avs_write <= w;
      i = 0;
      do begin
         @(posedge mclk);
         i++;
      end while (avs_waitrequest !== 1'b0 && i < 20);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (avs_waitrequest !== 1'b0) begin
         mismatches++;
         results();
      end
   endtask
   task rd(input logic [3:0] a, input logic [7:0] e);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, q);
      chk(q[7:0], e);
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task t_reset();
      rd(4'h0, 8'h00);
      rd(4'h8, 8'h00);
      rd(4'h2, 8'h00);
   endtask
   task t_addr();
      for (int k = 0; k < 4; k++) begin
         adr <= adr | (4'h1 << k);
         cyc(5);
         rd(4'h0, 8'h01);
      end
      wr(4'hc, 8'h40);
      rd(4'hc, 8'h40);
      adr <= 4'h4;
      cyc(5);
      rd(4'h0, 8'h00);
      wr(4'hc, 8'h80);
      adr <= 4'h5;
      cyc(5);
      rd(4'h0, 8'h00);
      adr <= 4'h4;
      wr(4'hc, 8'h00);
      wr(4'h0, 8'h01);
      adr <= 4'h6;
      cyc(5);
      chk({7'h0, irq}, 8'h01);
      wr(4'h4, 8'h01);
      cyc(3);
      chk({7'h0, irq}, 8'h00);
      wr(4'h0, 8'h00);
      adr <= 4'h4;
      cyc(5);
      chk({7'h0, irq}, 8'h00);
      rd(4'h0, 8'h01);
   endtask
   task t_srq();
      srq_on <= 1'b1;
      cyc(8);
      rd(4'h0, 8'h40);
      rd(4'h0, 8'h00);
      srq_on <= 1'b0;
      request_service <= 1'b1;
      data_valid <= 1'b1;
      cyc(8);
      srq_on <= 1'b1;
      cyc(8);
      rd(4'h0, 8'h00);
      srq_on <= 1'b0;
      cyc(8);
      request_service <= 1'b0;
      data_valid <= 1'b0;
      adr <= 4'h0;
      cyc(5);
      srq_on <= 1'b1;
      cyc(8);
      rd(4'h0, 8'h01);
      srq_on <= 1'b0;
   endtask
   task t_cmd();
      controller_active_state <= 1'b1;
      source_generate_state <= 1'b1;
      cyc(5);
      chk({7'h0, command_output_register_empty}, 8'h01);
      rd(4'h0, 8'h08);
      rd(4'h0, 8'h00);
      source_generate_state <= 1'b0;
      cyc(3);
      source_generate_state <= 1'b1;
      wr(4'h0, 8'h08);
      rd(4'h8, 8'h08);
      cyc(5);
      chk({7'h0, irq}, 8'h01);
      controller_active_state <= 1'b0;
      cyc(5);
      chk({7'h0, command_output_register_empty}, 8'h00);
      chk({7'h0, irq}, 8'h00);
      rd(4'h0, 8'h00);
      source_generate_state <= 1'b0;
      wr(4'h0, 8'h00);
   endtask
   task t_rl();
      ren_on <= 1'b1;
      cyc(8);
      chk({6'h0, lockout_indication, remote_indication}, 8'h00);
      wr(4'h0, 8'h04);
      lockout_cmd <= 1'b1;
      cyc(1);
      lockout_cmd <= 1'b0;
      cyc(5);
      chk({7'h0, irq}, 8'h01);
      rd(4'h0, 8'h24);
      listener_addressed <= 1'b1;
      cyc(5);
      chk({6'h0, lockout_indication, remote_indication}, 8'h03);
      rd(4'h0, 8'h32);
      cyc(3);
      chk({7'h0, irq}, 8'h00);
      wr(4'h0, 8'h00);
      ren_on <= 1'b0;
      listener_addressed <= 1'b0;
      cyc(8);
      chk({6'h0, lockout_indication, remote_indication}, 8'h00);
      rd(4'h0, 8'h06);
   endtask
   initial begin
      cyc(10);
      reset <= 1'b0;
      t_reset();
      t_addr();
      t_srq();
      t_cmd();
      t_rl();
      results();
   end
endmodule // tb_top
`default_nettype wire
